// ==== verilog/pors_top.sv ====
// Power-on and system reset sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pors_consts.svh"
module pors_top
   import pors_pkg::*;
#(
   parameter logic [23:0] LOCK_CYCLES = 24'(`PORS_LOCK_CYC)
)
(
   input wire logic core_clk, // Reference clock
   input wire logic reset, // Async reset
   input wire logic power_on_sense, // Monitor says power good
   input wire logic supply_fail_warning, // Low: supply about to fail
   input wire logic sys_reset_req, // Watchdog or strike reset pulse
   input wire logic low_power_req, // Software low power mode level
   input wire logic periph_release, // Processor releases clocks
   input wire logic rail_enable_req, // Processor enables 1.8 V rail
   input wire logic park_done, // Mirror array parked
   output logic master_pll_rst, // PLL reset, high active
   output logic cpu_rst, // Processor resets
   output logic periph_rst, // Other block resets
   output logic periph_clk_en, // Other clocks enable
   output logic cpu_clk_en, // Processor clocks enable
   output logic domains_on, // Power gating all on
   output logic hv_rail_en, // 1.8 V rail enable
   output logic io_oe_n, // Pad enable, low drives
   output logic park_req // Park the mirror array
);
   //////////////////////////////////////////////////////////////
   logic pos_sync;
   logic warn_sync;
   logic por_rst;
   pors_state_t state_q, state_d;
   logic [23:0] cnt_q, cnt_d;
   logic lowpwr_q, lowpwr_d;
   pors_ctl_t ctl_q, ctl_d;
   logic park_q, park_d;
   logic cnt_done;
   logic warn_hit;

   function automatic pors_ctl_t ctl_default(input logic keep_rail_off);
      pors_ctl_t c;
      c = '0;
      c.pll_rst = 1'b0;
      c.cpu_rst = 1'b0;
      c.periph_rst = 1'b1;
      c.periph_clk_en = 1'b0;
      c.cpu_clk_en = 1'b1;
      c.domains_on = 1'b1;
      c.hv_rail_en = !keep_rail_off;
      c.io_oe_n = 1'b0;
      return c;
   endfunction

   function automatic pors_ctl_t ctl_held(input logic pll_on);
      pors_ctl_t c;
      c = '0;
      c.pll_rst = !pll_on;
      c.cpu_rst = 1'b1;
      c.periph_rst = 1'b1;
      c.io_oe_n = 1'b1;
      return c;
   endfunction

   //////////////////////////////////////////////////////////////
   // Synchronisers
   pors_sync u_pos_sync
   (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(power_on_sense),
      .sync_out(pos_sync)
   );
   pors_sync u_warn_sync
   (
      .core_clk(core_clk),
      .reset(reset),
      .async_in(supply_fail_warning),
      .sync_out(warn_sync)
   );

   assign por_rst = reset | ~power_on_sense;
   assign cnt_done = (cnt_q == LOCK_CYCLES - `PORS_ONE_CNT);
   assign warn_hit = ~warn_sync;

   //////////////////////////////////////////////////////////////
   // Sequencer
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      lowpwr_d = lowpwr_q;
      ctl_d = ctl_q;
      park_d = 1'b0;
      unique case (state_q)
         PORS_OFF:
         begin
            ctl_d = ctl_held(1'b0);
            cnt_d = `PORS_ZERO_CNT;
            if (pos_sync)
            begin
               state_d = PORS_LOCK;
               ctl_d = ctl_held(1'b1);
            end
         end
         PORS_LOCK:
         begin
            cnt_d = cnt_q + `PORS_ONE_CNT;
            if (cnt_done)
            begin
               state_d = PORS_RUN;
               ctl_d = ctl_default(lowpwr_q);
            end
         end
         PORS_RUN:
         begin
            lowpwr_d = low_power_req;
            if (periph_release)
            begin
               ctl_d.periph_rst = 1'b0;
               ctl_d.periph_clk_en = 1'b1;
            end
            if (rail_enable_req)
               ctl_d.hv_rail_en = 1'b1;
            if (low_power_req)
               ctl_d.hv_rail_en = 1'b0;
            if (warn_hit)
            begin
               state_d = PORS_PARK;
               park_d = 1'b1;
               cnt_d = `PORS_ZERO_CNT;
            end
            else if (sys_reset_req)
               state_d = PORS_SYSRST;
         end
         PORS_PARK:
         begin
            park_d = 1'b1;
            cnt_d = cnt_q + `PORS_ONE_CNT;
            if (park_done || cnt_q == 24'(`PORS_PARK_CYC))
               state_d = PORS_SYSRST;
         end
         PORS_SYSRST:
         begin
            ctl_d = ctl_held(1'b1);
            ctl_d.io_oe_n = 1'b0;
            cnt_d = `PORS_ZERO_CNT;
            state_d = PORS_LOCK;
         end
         default:
         begin
            state_d = PORS_OFF;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge por_rst)
   begin
      if (por_rst)
      begin
         state_q <= PORS_OFF;
         cnt_q <= `PORS_ZERO_CNT;
         lowpwr_q <= 1'b0;
         ctl_q <= `PORS_CTL_RST;
         park_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         lowpwr_q <= lowpwr_d;
         ctl_q <= ctl_d;
         park_q <= park_d;
      end
   end

   assign master_pll_rst = ctl_q.pll_rst;
   assign cpu_rst = ctl_q.cpu_rst;
   assign periph_rst = ctl_q.periph_rst;
   assign periph_clk_en = ctl_q.periph_clk_en;
   assign cpu_clk_en = ctl_q.cpu_clk_en;
   assign domains_on = ctl_q.domains_on;
   assign hv_rail_en = ctl_q.hv_rail_en;
   assign io_oe_n = ctl_q.io_oe_n;
   assign park_req = park_q;

   //////////////////////////////////////////////////////////////
   // Checks
   pll_first_a: assert property (
      @(posedge core_clk) disable iff (por_rst)
      !master_pll_rst || cpu_rst)
      else $error("pll reset released after cpu");
   sense_hold_a: assert property (
      @(posedge core_clk) disable iff (reset)
      !power_on_sense |-> ##1 (cpu_rst && io_oe_n))
      else $error("sense low but not held");
   lock_wait_a: assert property (
      @(posedge core_clk) disable iff (por_rst)
      $fell(master_pll_rst) |-> ##1 cpu_rst)
      else $error("cpu released too early");
   cpu_release_a: assert property (
      @(posedge core_clk) disable iff (por_rst)
      $fell(cpu_rst) |-> (cpu_clk_en && domains_on))
      else $error("cpu released without defaults");
   periph_dflt_a: assert property (
      @(posedge core_clk) disable iff (por_rst)
      $fell(cpu_rst) |-> (periph_rst && !periph_clk_en))
      else $error("peripheral defaults wrong");
   rail_lowpwr_a: assert property (
      @(posedge core_clk) disable iff (por_rst)
      ($fell(cpu_rst) && lowpwr_q) |-> !hv_rail_en)
      else $error("rail on after low power reset");
   park_first_a: assert property (
      @(posedge core_clk) disable iff (por_rst)
      (state_q == PORS_RUN && warn_hit) |-> ##1 park_req)
      else $error("no park on fail warning");
   sysrst_dflt_a: assert property (
      @(posedge core_clk) disable iff (por_rst)
      (state_q == PORS_SYSRST) |-> ##1 (cpu_rst && periph_rst))
      else $error("system reset defaults missing");
endmodule
`default_nettype wire

// ==== pkg/pors_consts.svh ====
// Constants for the power-on reset sequencer
`ifndef PORS_CONSTS_SVH
`define PORS_CONSTS_SVH
`define PORS_CLK_HZ 10000000
`define PORS_LOCK_MS 60
`define PORS_LOCK_CYC ((`PORS_CLK_HZ / 1000) * `PORS_LOCK_MS)
`define PORS_CNT_W 24
`define PORS_PARK_CYC 16
`define PORS_SYNC_RST 2'h0
`define PORS_CTL_RST 8'hE1
`define PORS_ZERO_CNT 24'h000000
`define PORS_ONE_CNT 24'h000001
`endif

// ==== pkg/pors_pkg.sv ====
// Types for the power-on reset sequencer
package pors_pkg;
   typedef enum logic [4:0]
   {
      PORS_OFF = 5'h01,
      PORS_LOCK = 5'h02,
      PORS_RUN = 5'h04,
      PORS_PARK = 5'h08,
      PORS_SYSRST = 5'h10
   } pors_state_t;
   typedef struct packed
   {
      logic pll_rst;
      logic cpu_rst;
      logic periph_rst;
      logic periph_clk_en;
      logic cpu_clk_en;
      logic domains_on;
      logic hv_rail_en;
      logic io_oe_n;
   } pors_ctl_t;
endpackage

// ==== verilog/pors_sync.sv ====
// Two-stage synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
`include "pors_consts.svh"
module pors_sync
(
   input wire logic core_clk, // Clock
   input wire logic reset, // Async reset
   input wire logic async_in, // Raw level
   output logic sync_out // Synchronised level
);
   logic [1:0] stage_q;
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         stage_q <= `PORS_SYNC_RST;
      else
         stage_q <= {stage_q[0], async_in};
   end
   assign sync_out = stage_q[1];
endmodule
`default_nettype wire

// ==== testbench/pors_monitor.sv ====
// Power monitor and mirror-park responder model
`timescale 1ns/1ps
`default_nettype none
module pors_monitor
#(
   parameter int SETTLE = 5
)
(
   input wire logic core_clk, // Clock
   input wire logic power_up, // Supplies switched on
   input wire logic brownout, // Input supply sagging
   input wire logic park_req, // Park request
   input wire logic [3:0] park_delay, // Park time, 0 never
   output logic power_on_sense, // Power good
   output logic supply_fail_warning, // Low: supply failing
   output var logic park_done // Array parked
);
   int ramp = 0;
   int park_cnt = 0;
   logic sense_q = 1'b0;
   initial park_done = 1'b0;
   assign power_on_sense = power_up && sense_q;
   assign supply_fail_warning = !brownout;
   always @(posedge core_clk)
   begin
      // Sense rises only once every supply has ramped
      ramp <= power_up ? ((ramp < SETTLE) ? ramp + 1 : ramp) : 0;
      sense_q <= #10 power_up && ramp == SETTLE;
      park_cnt <= park_req ? park_cnt + 1 : 0;
      park_done <= #10 park_req && park_delay != 4'h0 &&
         park_cnt + 1 >= int'(park_delay);
   end
endmodule
`default_nettype wire

// ==== testbench/power_on_reset_sequencer_test.sv ====
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module power_on_reset_sequencer_test;
   import pors_pkg::*;
   localparam int LOCK = 20;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic power_up = 1'b0;
   logic brownout = 1'b0;
   logic sys_reset_req = 1'b0;
   logic low_power_req = 1'b0;
   logic periph_release = 1'b0;
   logic rail_enable_req = 1'b0;
   logic [3:0] park_delay = 4'h1;
   logic power_on_sense, supply_fail_warning, park_done, park_req;
   logic master_pll_rst, cpu_rst, periph_rst, periph_clk_en;
   logic cpu_clk_en, domains_on, hv_rail_en, io_oe_n;
   pors_ctl_t ctl;
   logic [8:0] obs;
   int n_errors = 0;
   int n_compared = 0;
   int n, d, rel, rail, k;
   assign ctl = {master_pll_rst, cpu_rst, periph_rst, periph_clk_en,
      cpu_clk_en, domains_on, hv_rail_en, io_oe_n};
   assign obs = {park_req, ctl};
   pors_top #(.LOCK_CYCLES(24'h000014)) dut_u (.core_clk, .reset,
      .power_on_sense, .supply_fail_warning, .sys_reset_req,
      .low_power_req, .periph_release, .rail_enable_req, .park_done,
      .master_pll_rst, .cpu_rst, .periph_rst, .periph_clk_en, .cpu_clk_en,
      .domains_on, .hv_rail_en, .io_oe_n, .park_req);
   pors_monitor mon_u (.core_clk, .power_up, .brownout, .park_req,
      .park_delay, .power_on_sense, .supply_fail_warning, .park_done);
   initial
   begin
      forever #50 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////
   // Reference outputs: 0 off, 2 running
   function automatic pors_ctl_t model_ctl(int st);
      if (st == 0)
         return pors_ctl_t'(8'hE1);
      return pors_ctl_t'({2'h0, rel == 0, rel != 0, 2'h3, rail != 0, 1'b0});
   endfunction
   task automatic test_done();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk_ctl(string what, pors_ctl_t exp, pors_ctl_t got);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_bit(string what, logic exp, logic got);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic tick(int c);
      repeat (c) @(posedge core_clk);
      #10;
   endtask
   task automatic wait_out(int idx, logic v, int lim, output int cnt);
      cnt = 0;
      while (obs[idx] !== v)
      begin
         if (cnt == lim)
         begin
            n_errors++;
            $display("mismatch wait bit %0d expected %b seen %b", idx, v,
               obs[idx]);
            test_done();
         end
         tick(1);
         cnt++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(77218));
      rel = 0;
      rail = 1;
      tick(4);
      reset = 1'b0;
      tick(3);
      chk_ctl("held off", model_ctl(0), ctl);
      power_up = 1'b1;
      wait_out(7, 1'b0, 20, n);
      chk_bit("cpu after pll", 1'b1, cpu_rst);
      wait_out(6, 1'b0, LOCK + 5, n);
      chk_bit("lock span", 1'b1, n >= LOCK && n <= LOCK + 1);
      chk_ctl("run", model_ctl(2), ctl);
      periph_release = 1'b1;
      rel = 1;
      tick(3);
      chk_ctl("released", model_ctl(2), ctl);
      low_power_req = 1'b1;
      rail = 0;
      tick(3);
      chk_ctl("low power", model_ctl(2), ctl);
      periph_release = 1'b0;
      sys_reset_req = 1'b1;
      tick(1);
      sys_reset_req = 1'b0;
      rel = 0;
      wait_out(6, 1'b1, 4, n);
      chk_bit("sys periph", 1'b1, periph_rst);
      wait_out(6, 1'b0, LOCK + 8, n);
      chk_ctl("relock", model_ctl(2), ctl);
      low_power_req = 1'b0;
      rail_enable_req = 1'b1;
      rail = 1;
      tick(3);
      rail_enable_req = 1'b0;
      chk_ctl("rail on", model_ctl(2), ctl);
      for (k = 0; k < 4; k++)
      begin
         d = (k == 3) ? 0 : $urandom_range(1, 8);
         park_delay = 4'(d);
         brownout = 1'b1;
         wait_out(8, 1'b1, 8, n);
         chk_bit("cpu in park", 1'b0, cpu_rst);
         wait_out(8, 1'b0, 25, n);
         if (d == 0)
            d = 16;
         chk_bit("park span", 1'b1, n >= d - 1 && n <= d + 3);
         wait_out(6, 1'b1, 3, n);
         brownout = 1'b0;
         wait_out(6, 1'b0, LOCK + 10, n);
         chk_ctl("after park", model_ctl(2), ctl);
      end
      power_up = 1'b0;
      #20;
      chk_ctl("sense drop", model_ctl(0), ctl);
      test_done();
   end
endmodule
`default_nettype wire
